/* File: pkg/smrc_pkg.sv */
// Shared constants and types for the supply monitor and reset control block
package smrc_pkg;

   // ------------------------------------------------------------------
   // Register map: indices, byte address is four times the index
   // ------------------------------------------------------------------
   localparam int          ADDR_W          = 32;
   localparam logic [15:0] IDX_CLEAR_CTRL  = 16'hff80;
   localparam logic [15:0] IDX_DETECT_CTRL = 16'hff81;
   localparam logic [15:0] IDX_LEVEL_SEL   = 16'hff82;

   // ------------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------------
   localparam int CAUSE_BIT   = 2;
   localparam int MASK_BIT    = 1;
   localparam int STOP_BIT    = 0;
   localparam int DET_EN_BIT  = 7;
   localparam int DET_OUT_BIT = 0;
   localparam int LEVEL_W     = 3;
   localparam int SYNC_STAGES = 2;

   // ------------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------------
   localparam logic [7:0] CLEAR_CTRL_RST   = 8'h00;
   localparam logic [7:0] CLEAR_CTRL_POC   = 8'h04;
   localparam logic [7:0] DETECT_CTRL_RST  = 8'h00;
   localparam logic [7:0] LEVEL_SEL_RST    = 8'h00;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SMRC_POC_SWITCH     = 2'b00,
      SMRC_POC_ALWAYS_ON  = 2'b01,
      SMRC_POC_ALWAYS_OFF = 2'b10
   } smrc_poc_variant_t;

   typedef struct packed {
      logic cause;
      logic mask;
      logic stop;
   } smrc_clear_ctrl_t;

   typedef struct packed {
      logic enable;
      logic out_flag;
   } smrc_detect_t;

   function automatic logic [ADDR_W-1:0] smrc_byte_addr(
      input logic [15:0] idx
   );
      return {14'h0000, idx, 2'b00};
   endfunction : smrc_byte_addr

endpackage : smrc_pkg

/* File: verilog/smrc_sync.sv */
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module smrc_sync
   import smrc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule : smrc_sync

/* File: verilog/smrc_rise.sv */
// Rising-edge detector giving a one-cycle pulse
`timescale 1ns/10ps
module smrc_rise
   import smrc_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level_in,
   output logic      rise_pulse
);

   logic last_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_ff <= 1'b0;
      end else begin
         last_ff <= level_in;
      end
   end

   assign rise_pulse = level_in & ~last_ff;

endmodule : smrc_rise

/* File: verilog/smrc_top.sv */
// Supply monitor and reset control block with its APB register file
`timescale 1ns/10ps

// Operation
// - Active unmasked clear monitor, low supply: reset
// - Clear monitor keeps running in standby
// - Enabled detector, low supply: raise interrupt
// - Detector stops during standby
// - Variant: switchable, always on, always off
// - Programmable part forces the switchable variant
// - Cause flag bit 2 marks monitor reset
// - Mask bit 1 blocks monitor reset
// - Stop bit 0 halts the monitor
// - Control resets 00H, 04H after monitor reset
// - Control register takes bit or byte writes
// - Detector enable bit gates the detector
// - Read-only output flag shows low supply
// - Detector control clears to 00H on reset
// - Three-bit level select, upper bits zero
// - Writing control bits 0 to 2 clears cause
// - Interrupt only on comparator rising edge; also raised when enable or standby exit finds the comparator low
// - Enable is bit 7; detection waits for it
module smrc_top
   import smrc_pkg::*;
#(
   parameter smrc_poc_variant_t POC_VARIANT      = SMRC_POC_SWITCH,
   parameter bit                PROGRAMMABLE_PART = 1'b0
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              clear_cmp_low,
   input  wire logic              detect_cmp_low,
   input  wire logic              standby,
   output logic                   internal_reset,
   output logic                   low_supply_irq,
   output logic      [LEVEL_W-1:0] detect_level,
   output logic                   detect_power_on
);

   // ------------------------------------------------------------------
   // Variant selection
   // ------------------------------------------------------------------
   // A programmable part carries only the switchable monitor
   localparam smrc_poc_variant_t EFF_VARIANT =
      PROGRAMMABLE_PART ? SMRC_POC_SWITCH : POC_VARIANT;
   localparam bit IS_SWITCH = (EFF_VARIANT == SMRC_POC_SWITCH);
   localparam bit IS_ON     = (EFF_VARIANT == SMRC_POC_ALWAYS_ON);

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   smrc_clear_ctrl_t   clear_ff;
   smrc_clear_ctrl_t   nxt_clear;
   logic               det_en_ff;
   logic               nxt_det_en;
   logic [LEVEL_W-1:0] level_ff;
   logic [LEVEL_W-1:0] nxt_level;
   logic               det_pwr_ff;
   logic               nxt_det_pwr;
   logic               int_reset_ff;
   logic               nxt_int_reset;
   logic               irq_ff;
   logic [31:0]        rdata_ff;
   logic [31:0]        nxt_rdata;

   // ------------------------------------------------------------------
   // Comparator synchronisation
   // ------------------------------------------------------------------
   logic [1:0] cmp_sync;
   logic       clear_low_s;
   logic       detect_low_s;

   smrc_sync #(
      .WIDTH    (2)
   ) u_cmp_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({clear_cmp_low, detect_cmp_low}),
      .sync_out (cmp_sync)
   );

   assign clear_low_s  = cmp_sync[1];
   assign detect_low_s = cmp_sync[0];

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   wire hit_clear  = (paddr == smrc_byte_addr(IDX_CLEAR_CTRL));
   wire hit_detect = (paddr == smrc_byte_addr(IDX_DETECT_CTRL));
   wire hit_level  = (paddr == smrc_byte_addr(IDX_LEVEL_SEL));
   wire hit_any    = hit_clear | hit_detect | hit_level;
   wire access     = psel & penable;
   wire setup      = psel & ~penable;
   // Only the low byte lane holds register bits
   wire lane0      = pstrb[0];
   wire wr_ok      = access & pwrite & hit_any & lane0;
   wire wr_clear   = wr_ok & hit_clear;
   wire wr_detect  = wr_ok & hit_detect;
   wire wr_level   = wr_ok & hit_level;

   // ------------------------------------------------------------------
   // Clear monitor
   // ------------------------------------------------------------------
   // Stop and mask bits matter only in the switchable variant
   wire poc_active = IS_SWITCH ? ~clear_ff.stop : IS_ON;
   wire poc_mask   = IS_SWITCH & clear_ff.mask;
   // Standby does not gate this path, so the monitor works in it
   wire poc_fire   = poc_active & clear_low_s & ~poc_mask;

   assign nxt_int_reset = poc_fire;

   // ------------------------------------------------------------------
   // Low-voltage detector
   // ------------------------------------------------------------------
   // Comparator bank powers up on enable and only drops at standby
   // or reset; clearing the enable bit leaves it running.
   assign nxt_det_pwr = standby          ? 1'b0 :
                        det_en_ff        ? 1'b1 :
                                           det_pwr_ff;

   wire det_active = det_en_ff & ~standby;
   wire det_low    = det_active & detect_low_s;
   wire det_rise;

   smrc_rise u_det_rise (
      .pclk       (pclk),
      .presetn    (presetn),
      .level_in   (det_low),
      .rise_pulse (det_rise)
   );

   // ------------------------------------------------------------------
   // Next register values
   // ------------------------------------------------------------------
   always_comb begin
      nxt_clear = clear_ff;
      if (wr_clear) begin
         nxt_clear.stop  = pwdata[STOP_BIT];
         nxt_clear.mask  = pwdata[MASK_BIT];
         nxt_clear.cause = 1'b0;
      end
      // A monitor reset wins over a same-cycle write
      if (int_reset_ff) begin
         nxt_clear = smrc_clear_ctrl_t'(CLEAR_CTRL_POC[2:0]);
      end
   end

   assign nxt_det_en = int_reset_ff ? DETECT_CTRL_RST[DET_EN_BIT] :
                       wr_detect    ? pwdata[DET_EN_BIT] :
                                      det_en_ff;

   assign nxt_level  = int_reset_ff ? LEVEL_SEL_RST[LEVEL_W-1:0] :
                       wr_level     ? pwdata[LEVEL_W-1:0] :
                                      level_ff;

   // ------------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ------------------------------------------------------------------
   wire [7:0] rd_clear  = {5'b0_0000, clear_ff.cause,
                           clear_ff.mask, clear_ff.stop};
   wire [7:0] rd_detect = {det_en_ff, 6'b00_0000, det_low};
   wire [7:0] rd_level  = {5'b0_0000, level_ff};

   assign nxt_rdata = !setup     ? rdata_ff :
                      hit_clear  ? {24'h00_0000, rd_clear} :
                      hit_detect ? {24'h00_0000, rd_detect} :
                      hit_level  ? {24'h00_0000, rd_level} :
                                   32'h0000_0000;

   // ------------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_ff     <= smrc_clear_ctrl_t'(CLEAR_CTRL_RST[2:0]);
         det_en_ff    <= DETECT_CTRL_RST[DET_EN_BIT];
         level_ff     <= LEVEL_SEL_RST[LEVEL_W-1:0];
         det_pwr_ff   <= 1'b0;
         int_reset_ff <= 1'b0;
         irq_ff       <= 1'b0;
         rdata_ff     <= 32'h0000_0000;
      end else begin
         clear_ff     <= nxt_clear;
         det_en_ff    <= nxt_det_en;
         level_ff     <= nxt_level;
         det_pwr_ff   <= nxt_det_pwr;
         int_reset_ff <= nxt_int_reset;
         irq_ff       <= det_rise;
         rdata_ff     <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Zero wait states; unmapped addresses answer with an error
   assign pready          = 1'b1;
   assign pslverr         = access & ~hit_any;
   assign prdata          = rdata_ff;
   assign internal_reset  = int_reset_ff;
   assign low_supply_irq  = irq_ff;
   assign detect_level    = level_ff;
   assign detect_power_on = det_pwr_ff;

endmodule : smrc_top

/* File: test/smrc_supply_model.sv */
// Behavioural model of the two analog supply comparators
`timescale 1ns/10ps
module smrc_supply_model (
   input  wire logic       pclk,
   input  wire logic       want_clear,
   input  wire logic       want_detect,
   input  wire logic [3:0] lag,
   output logic            clear_cmp_low,
   output logic            detect_cmp_low
);
   logic [3:0] wait_ff;
   initial begin
      clear_cmp_low = 1'b0;
      detect_cmp_low = 1'b0;
      wait_ff = 4'h0;
   end
   // A slow comparator follows the supply only after lag cycles
   always @(posedge pclk) begin
      if ({want_clear, want_detect} == {clear_cmp_low, detect_cmp_low}) begin
         wait_ff <= 4'h0;
      end else if (wait_ff >= lag) begin
         clear_cmp_low <= want_clear;
         detect_cmp_low <= want_detect;
         wait_ff <= 4'h0;
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule : smrc_supply_model

/* File: test/smrc_asserts.sv */
// Port-level assertions for the supply monitor block
`timescale 1ns/10ps
module smrc_asserts
   import smrc_pkg::*;
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [ADDR_W-1:0]  paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               clear_cmp_low,
   input wire logic               detect_cmp_low,
   input wire logic               standby,
   input wire logic               internal_reset,
   input wire logic               low_supply_irq,
   input wire logic [LEVEL_W-1:0] detect_level,
   input wire logic               detect_power_on
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire        acc = psel && penable;
   wire        wr0 = acc && pwrite && pstrb[0];
   wire [15:0] idx = paddr[17:2];
   wire        mapped = paddr[31:18] == 14'h0000 && paddr[1:0] == 2'b00 &&
      (idx == IDX_CLEAR_CTRL || idx == IDX_DETECT_CTRL || idx == IDX_LEVEL_SEL);
   sequence s_wr_level;
      wr0 && idx == IDX_LEVEL_SEL && !internal_reset;
   endsequence
   sequence s_enable;
      wr0 && idx == IDX_DETECT_CTRL && pwdata[DET_EN_BIT] && !standby &&
      !internal_reset ##1 !standby && !internal_reset;
   endsequence
   a_ready_now: assert property (acc |-> pready)
      else $error("pready low in access phase");
   a_err_unmapped: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_level_drive: assert property (s_wr_level |=> detect_level == $past(pwdata[2:0]))
      else $error("detect_level does not follow write");
   a_reset_cause: assert property ($rose(internal_reset) |->
      $past(clear_cmp_low, 2) || $past(clear_cmp_low, 3) || $past(clear_cmp_low, 4))
      else $error("internal_reset without low supply");
   a_irq_pulse: assert property (low_supply_irq |=> !low_supply_irq)
      else $error("irq longer than one cycle");
   a_irq_cause: assert property (low_supply_irq |-> $past(detect_cmp_low, 2) ||
      $past(detect_cmp_low, 3) || $past(detect_cmp_low, 4) || $past(detect_cmp_low, 5))
      else $error("irq without low supply");
   a_irq_standby: assert property (standby [*3] |-> !low_supply_irq)
      else $error("irq during standby");
   a_power_on: assert property (s_enable |=> detect_power_on)
      else $error("detector not powered after enable");
endmodule : smrc_asserts

bind smrc_top smrc_asserts smrc_asserts_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .clear_cmp_low(clear_cmp_low),
   .detect_cmp_low(detect_cmp_low), .standby(standby),
   .internal_reset(internal_reset), .low_supply_irq(low_supply_irq),
   .detect_level(detect_level), .detect_power_on(detect_power_on));

/* File: test/test_supply_monitor_reset_ctrl.sv */
// Self-checking bench for the supply monitor and reset control block
`timescale 1ns/10ps
module test_supply_monitor_reset_ctrl;
   import smrc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby, err;
   logic clear_cmp_low, detect_cmp_low, want_clr, want_det;
   logic internal_reset, low_supply_irq, detect_power_on;
   logic [ADDR_W-1:0]  paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic [3:0]         pstrb, lag;
   logic [LEVEL_W-1:0] detect_level;
   int                 n_mismatch = 0;
   int                 checks_done = 0;
   int                 h;
   smrc_top smrc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clear_cmp_low(clear_cmp_low), .detect_cmp_low(detect_cmp_low),
      .standby(standby), .internal_reset(internal_reset),
      .low_supply_irq(low_supply_irq), .detect_level(detect_level),
      .detect_power_on(detect_power_on));
   smrc_supply_model smrc_supply_model_inst (.pclk(pclk), .want_clear(want_clr),
      .want_detect(want_det), .lag(lag), .clear_cmp_low(clear_cmp_low),
      .detect_cmp_low(detect_cmp_low));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task summarize;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : chk
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
            input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0000, idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd_chk(input string what, input logic [15:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, 4'h0);
      chk(what, {24'h00_0000, e}, rd);
   endtask : rd_chk
   // Counts cycles in which the chosen output is seen high
   task watch(input bit irq, input int cyc);
      h = 0;
      // Sampling on the rising edge leaves the bench on that edge, so
      // stimulus that follows is driven there and not on the falling edge
      repeat (cyc) begin
         @(posedge pclk);
         if ((irq ? low_supply_irq : internal_reset) === 1'b1) h++;
      end
   endtask : watch
   task t_reset_vals;
      rd_chk("clear ctrl", IDX_CLEAR_CTRL, CLEAR_CTRL_RST);
      rd_chk("detect ctrl", IDX_DETECT_CTRL, DETECT_CTRL_RST);
      rd_chk("level", IDX_LEVEL_SEL, LEVEL_SEL_RST);
      apb(1'b0, 16'h0001, 8'h00, 4'h0);
      chk("unmapped err", 32'h0000_0001, {31'h0, err});
   endtask : t_reset_vals
   task t_levels;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, IDX_LEVEL_SEL, {5'h1f, i[2:0]}, 4'h1);
         rd_chk("level", IDX_LEVEL_SEL, {5'h00, i[2:0]});
         chk("level pin", i, {29'h0, detect_level});
      end
      apb(1'b1, IDX_LEVEL_SEL, 8'h05, 4'h0);
      rd_chk("level strobe", IDX_LEVEL_SEL, 8'h07);
   endtask : t_levels
   task t_clear;
      lag <= 4'h6;
      want_clr <= 1'b1;
      watch(1'b0, 16);
      chk("reset raised", 1, h > 0);
      want_clr <= 1'b0;
      watch(1'b0, 12);
      rd_chk("cause set", IDX_CLEAR_CTRL, CLEAR_CTRL_POC);
      apb(1'b1, IDX_CLEAR_CTRL, 8'hf8, 4'h1);
      rd_chk("cause clear", IDX_CLEAR_CTRL, 8'h00);
      apb(1'b1, IDX_CLEAR_CTRL, 8'h02, 4'h1);
      want_clr <= 1'b1;
      watch(1'b0, 16);
      chk("masked", 0, h);
      apb(1'b1, IDX_CLEAR_CTRL, 8'h03, 4'h1);
      apb(1'b1, IDX_CLEAR_CTRL, 8'h01, 4'h1);
      watch(1'b0, 12);
      chk("stopped", 0, h);
      standby <= 1'b1;
      apb(1'b1, IDX_CLEAR_CTRL, 8'h00, 4'h1);
      watch(1'b0, 12);
      chk("standby reset", 1, h > 0);
      standby <= 1'b0;
      want_clr <= 1'b0;
      watch(1'b0, 12);
   endtask : t_clear
   task t_detect;
      lag <= 4'h0;
      repeat (20) @(posedge pclk);
      want_det <= 1'b1;
      watch(1'b1, 20);
      chk("irq disabled", 0, h);
      rd_chk("flag disabled", IDX_DETECT_CTRL, 8'h00);
      apb(1'b1, IDX_DETECT_CTRL, 8'h80, 4'h1);
      watch(1'b1, 20);
      chk("irq enable", 1, h);
      rd_chk("flag low", IDX_DETECT_CTRL, 8'h81);
      chk("power on", 1, {31'h0, detect_power_on});
      want_det <= 1'b0;
      watch(1'b1, 10);
      rd_chk("flag high", IDX_DETECT_CTRL, 8'h80);
      want_det <= 1'b1;
      watch(1'b1, 20);
      chk("irq rise", 1, h);
      want_det <= 1'b0;
      standby <= 1'b1;
      watch(1'b1, 8);
      want_det <= 1'b1;
      watch(1'b1, 20);
      chk("irq standby", 0, h);
      chk("power off", 0, {31'h0, detect_power_on});
      want_det <= 1'b0;
      watch(1'b1, 8);
      standby <= 1'b0;
   endtask : t_detect
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, standby, want_clr, want_det} = 6'h00;
      paddr = '0;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      lag = 4'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals();
      t_levels();
      t_clear();
      t_detect();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      summarize();
   end
endmodule : test_supply_monitor_reset_ctrl
